// ===== gcr_map.vh
// register map, field positions, reset values and timing counts of the global control bank
`ifndef GCR_MAP_VH
`define GCR_MAP_VH

// register indexes; byte address is four times the index
`define GCR_IDX_SNIFF      6'h05
`define GCR_IDX_MII        6'h06
`define GCR_IDX_STORM_LOW  6'h07
`define GCR_IDX_TEST_ONE   6'h08
`define GCR_IDX_TEST_TWO   6'h09
`define GCR_IDX_TEST_THREE 6'h0A
`define GCR_IDX_POWER_LED  6'h0B

// field positions
`define GCR_SNIFF_AND_BIT  0
`define GCR_MII_BP_BIT     7
`define GCR_MII_HALF_BIT   6
`define GCR_MII_FLOW_BIT   5
`define GCR_MII_10M_BIT    4
`define GCR_MII_NULLVID_BIT 3
`define GCR_PWR_SAVE_BIT   3
`define GCR_LED_MODE_BIT   1

// reset values
`define GCR_RST_SNIFF      8'h00
`define GCR_RST_STORM_HIGH 3'h0
`define GCR_RST_STORM_LOW  8'h4A
`define GCR_RST_TEST       8'h24
`define GCR_RST_ZERO       8'h00

// axi answers
`define GCR_RESP_OKAY      2'h0
`define GCR_RESP_SLVERR    2'h2

// timing
`define GCR_CLK_HZ         20000000
`define GCR_STORM_100_MS   50
`define GCR_STORM_10_MS    500
`define GCR_STORM_100_CYC  ((`GCR_STORM_100_MS * `GCR_CLK_HZ) / 1000)
`define GCR_STORM_10_TICKS (`GCR_STORM_10_MS / `GCR_STORM_100_MS)
`define GCR_PORTS          5

`endif

// ===== gcr_sync.v
// two-flop synchroniser for a group of pin levels
module gcr_sync #(
	parameter W = 4
) (
	input  wire         aclk,   // core clock
	input  wire [W-1:0] d_in,   // asynchronous levels
	output wire [W-1:0] q_out   // synchronised levels
);

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta_r;
			reg sync_r;
			// first flop feeds only the second
			always @(posedge aclk) begin
				meta_r <= d_in[i];
				sync_r <= meta_r;
			end
			assign q_out[i] = sync_r;
		end
	endgenerate

endmodule

// ===== gcr_led_mux.v
// per-port LED meaning select, registered outputs
module gcr_led_mux #(
	parameter N = 5
) (
	input  wire         aclk,          // core clock
	input  wire         aresetn,       // sync reset, active low
	input  wire         ce,            // clock enable
	input  wire         led_mode,      // 0 or 1
	input  wire [N-1:0] link_up,       // port link
	input  wire [N-1:0] activity,      // port activity
	input  wire [N-1:0] full_duplex,   // port duplex
	input  wire [N-1:0] collision,     // port collision
	input  wire [N-1:0] speed_100,     // port speed
	output reg  [N-1:0] port_led_two,  // led 2
	output reg  [N-1:0] port_led_one,  // led 1
	output reg  [N-1:0] port_led_zero  // led 0
);

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_port
			wire lnk_act;
			assign lnk_act = link_up[i] & ~activity[i];
			// mode 0: link/act, duplex/col, speed; mode 1: 100 lnk/act, 10 lnk/act, duplex
			always @(posedge aclk) begin
				if (!aresetn) begin
					port_led_two[i]  <= 1'b0;
					port_led_one[i]  <= 1'b0;
					port_led_zero[i] <= 1'b0;
				end else if (ce) begin
					if (led_mode) begin
						port_led_two[i]  <= lnk_act & speed_100[i];
						port_led_one[i]  <= lnk_act & ~speed_100[i];
						port_led_zero[i] <= full_duplex[i];
					end else begin
						port_led_two[i]  <= lnk_act;
						port_led_one[i]  <= full_duplex[i] | collision[i];
						port_led_zero[i] <= speed_100[i];
					end
				end
			end
		end
	endgenerate

endmodule

// ===== gcr_regs.v
// global control register bank with axi4-lite slave, strap capture and storm limiter
`include "gcr_map.vh"
module gcr_regs #(
	parameter P_PERIOD_CYC = `GCR_STORM_100_CYC
) (
	input  wire        aclk,                    // core clock 20 MHz
	input  wire        aresetn,                 // sync reset, active low
	input  wire        ce,                      // clock enable, freezes state except the strap synchroniser flops
	// axi4-lite write address
	input  wire        s_axi_awvalid,           // address valid
	output wire        s_axi_awready,           // address ready
	input  wire [7:0]  s_axi_awaddr,            // byte address
	input  wire [2:0]  s_axi_awprot,            // unused
	// axi4-lite write data
	input  wire        s_axi_wvalid,            // data valid
	output wire        s_axi_wready,            // data ready
	input  wire [31:0] s_axi_wdata,             // data
	input  wire [3:0]  s_axi_wstrb,             // byte enables
	// axi4-lite write response
	output reg         s_axi_bvalid,            // response valid
	input  wire        s_axi_bready,            // response ready
	output reg  [1:0]  s_axi_bresp,             // response code
	// axi4-lite read address
	input  wire        s_axi_arvalid,           // address valid
	output wire        s_axi_arready,           // address ready
	input  wire [7:0]  s_axi_araddr,            // byte address
	input  wire [2:0]  s_axi_arprot,            // unused
	// axi4-lite read data
	output reg         s_axi_rvalid,            // data valid
	input  wire        s_axi_rready,            // data ready
	output reg  [31:0] s_axi_rdata,             // data
	output reg  [1:0]  s_axi_rresp,             // response code
	// strap pins
	input  wire        duplex_strap_pin,        // half duplex when high
	input  wire        flow_control_strap_pin,  // flow control when high
	input  wire        speed_strap_pin,         // 10M when high
	input  wire        led_mode_strap_pin,      // led mode 1 when high
	// sniff decision
	input  wire        sniff_src_match,         // source port monitored
	input  wire        sniff_dst_match,         // destination port monitored
	output wire        sniff_mirror,            // mirror this packet
	// switch mii settings
	output wire        mii_back_pressure,       // half-duplex back pressure on
	output wire        mii_half_duplex,         // half duplex
	output wire        mii_full_duplex,         // full duplex
	output wire        mii_flow_control,        // full-duplex pause on
	output wire        mii_speed_10,            // 10 Mb/s when high
	// null vid replacement
	input  wire        vid_valid,               // vid_in strobe
	input  wire [11:0] vid_in,                  // received vlan id
	input  wire [11:0] port_vid,                // ingress port vid
	output reg         vid_out_valid,           // vid_out strobe
	output reg  [11:0] vid_out,                 // resulting vlan id
	// broadcast storm limiter
	input  wire [4:0]  storm_enable,            // per-port protection on
	input  wire [4:0]  port_is_10m,             // per-port speed
	input  wire [4:0]  block_request,           // 64-byte block offered
	output wire [4:0]  block_accept,            // block allowed
	output wire [4:0]  storm_limited,           // port at its threshold
	// power and leds
	output wire        phy_power_save,          // phy power saving on
	input  wire [4:0]  link_up,                 // port link
	input  wire [4:0]  activity,                // port activity
	input  wire [4:0]  full_duplex,             // port duplex
	input  wire [4:0]  collision,               // port collision
	input  wire [4:0]  speed_100,               // port speed
	output wire [4:0]  port_led_two,            // led 2 per port
	output wire [4:0]  port_led_one,            // led 1 per port
	output wire [4:0]  port_led_zero            // led 0 per port
);

	// counts cut to the counter widths; the default period fits in 24 bits
	localparam integer PERIOD_INT  = P_PERIOD_CYC - 1;
	localparam integer TICKS_INT   = `GCR_STORM_10_TICKS - 1;
	localparam [23:0]  PERIOD_LAST = PERIOD_INT[23:0];
	localparam [3:0]   TICKS_LAST  = TICKS_INT[3:0];

	// register storage
	// one byte per register, control nine keeps its low nibble
	reg  [7:0]  sniff_r;
	reg  [7:0]  mii_r;
	reg  [7:0]  storm_low_r;
	reg  [7:0]  test_one_r;
	reg  [7:0]  test_two_r;
	reg  [7:0]  test_three_r;
	reg  [3:0]  power_led_r;
	reg         strap_pend_r;

	// write channel state
	// one address and one data beat held until the response
	reg         aw_have_r;
	reg         w_have_r;
	reg  [5:0]  aw_idx_r;
	reg  [7:0]  w_data_r;
	reg         w_lane_r;

	// decode and handshake nets
	wire [3:0]  strap_sync;
	wire        do_write;
	wire        w_hit;
	wire        ar_take;
	wire [5:0]  ar_idx;
	reg  [7:0]  rd_byte;
	reg         rd_hit;
	wire [10:0] storm_thr;

	// strap pins cross into the core clock
	// the capture below reads only the second flop
	gcr_sync #(
		.W (4)
	) u_sync (
		.aclk  (aclk),
		.d_in  ({duplex_strap_pin, flow_control_strap_pin, speed_strap_pin,
			led_mode_strap_pin}),
		.q_out (strap_sync)
	);

	// bus handshakes
	// readies drop while an item is held or a response waits
	assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write      = aw_have_r & w_have_r & ~s_axi_bvalid;
	assign ar_take       = s_axi_arvalid & s_axi_arready;
	assign ar_idx        = s_axi_araddr[7:2];

	// write address and data latches
	// address and data may be taken in either order or together
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_idx_r  <= 6'h00;
			w_data_r  <= 8'h00;
			w_lane_r  <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_idx_r  <= s_axi_awaddr[7:2];
			end else if (do_write) begin
				aw_have_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_have_r <= 1'b0;
			end
		end
	end

	// address decode for writes
	// indexes outside the bank answer slverr and write nothing
	assign w_hit = (aw_idx_r >= `GCR_IDX_SNIFF) && (aw_idx_r <= `GCR_IDX_POWER_LED);

	// write response
	// bresp stands with bvalid until the edge that sees bready
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `GCR_RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= w_hit ? `GCR_RESP_OKAY : `GCR_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register file; strap levels load once after reset release
	// a write needs two edges, so it never meets the strap load
	always @(posedge aclk) begin
		if (!aresetn) begin
			sniff_r      <= `GCR_RST_SNIFF;
			mii_r        <= {5'h00, `GCR_RST_STORM_HIGH};
			storm_low_r  <= `GCR_RST_STORM_LOW;
			test_one_r   <= `GCR_RST_TEST;
			test_two_r   <= `GCR_RST_TEST;
			test_three_r <= `GCR_RST_TEST;
			power_led_r  <= 4'h0;
			strap_pend_r <= 1'b1;
		end else if (ce) begin
			if (strap_pend_r) begin
				strap_pend_r                  <= 1'b0;
				mii_r[`GCR_MII_HALF_BIT]      <= strap_sync[3];
				mii_r[`GCR_MII_FLOW_BIT]      <= strap_sync[2];
				mii_r[`GCR_MII_10M_BIT]       <= strap_sync[1];
				power_led_r[`GCR_LED_MODE_BIT] <= strap_sync[0];
			end else if (do_write && w_lane_r) begin
				case (aw_idx_r)
					`GCR_IDX_SNIFF:      sniff_r      <= w_data_r;
					`GCR_IDX_MII:        mii_r        <= w_data_r;
					`GCR_IDX_STORM_LOW:  storm_low_r  <= w_data_r;
					`GCR_IDX_TEST_ONE:   test_one_r   <= w_data_r;
					`GCR_IDX_TEST_TWO:   test_two_r   <= w_data_r;
					`GCR_IDX_TEST_THREE: test_three_r <= w_data_r;
					`GCR_IDX_POWER_LED:  power_led_r  <= w_data_r[3:0];
					default:             sniff_r      <= sniff_r;
				endcase
			end
		end
	end

	// read mux; upper nibble of control nine reads zero
	// unmapped indexes read zero
	always @* begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		case (ar_idx)
			`GCR_IDX_SNIFF:      rd_byte = sniff_r;
			`GCR_IDX_MII:        rd_byte = mii_r;
			`GCR_IDX_STORM_LOW:  rd_byte = storm_low_r;
			`GCR_IDX_TEST_ONE:   rd_byte = test_one_r;
			`GCR_IDX_TEST_TWO:   rd_byte = test_two_r;
			`GCR_IDX_TEST_THREE: rd_byte = test_three_r;
			`GCR_IDX_POWER_LED:  rd_byte = {4'h0, power_led_r};
			default:             rd_hit  = 1'b0;
		endcase
	end

	// read data channel
	// rdata stands with rvalid; arready is low meanwhile
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `GCR_RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_byte};
				s_axi_rresp  <= rd_hit ? `GCR_RESP_OKAY : `GCR_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// sniff match combine
	// and-mode needs both ports to match, or-mode either
	assign sniff_mirror = sniff_r[`GCR_SNIFF_AND_BIT] ?
		(sniff_src_match & sniff_dst_match) :
		(sniff_src_match | sniff_dst_match);

	// switch mii controls
	// pause only in full duplex, back pressure only in half
	assign mii_half_duplex   = mii_r[`GCR_MII_HALF_BIT];
	assign mii_full_duplex   = ~mii_r[`GCR_MII_HALF_BIT];
	assign mii_back_pressure = mii_r[`GCR_MII_BP_BIT] & mii_half_duplex;
	assign mii_flow_control  = mii_r[`GCR_MII_FLOW_BIT] & mii_full_duplex;
	assign mii_speed_10      = mii_r[`GCR_MII_10M_BIT];
	assign phy_power_save    = power_led_r[`GCR_PWR_SAVE_BIT];

	// null vid replacement, one cycle latency
	// a null id takes the port id only while replacement is on
	always @(posedge aclk) begin
		if (!aresetn) begin
			vid_out_valid <= 1'b0;
			vid_out       <= 12'h000;
		end else if (ce) begin
			vid_out_valid <= vid_valid;
			if (vid_valid) begin
				if (mii_r[`GCR_MII_NULLVID_BIT] && vid_in == 12'h000) begin
					vid_out <= port_vid;
				end else begin
					vid_out <= vid_in;
				end
			end
		end
	end

	// storm threshold and the 50 ms base tick
	// threshold counts 64-byte blocks; base period shared by all ports
	assign storm_thr = {mii_r[2:0], storm_low_r};

	// base period counter
	reg  [23:0] period_cnt_r;
	wire        base_tick;
	assign base_tick = (period_cnt_r == PERIOD_LAST);

	always @(posedge aclk) begin
		if (!aresetn) begin
			period_cnt_r <= 24'h000000;
		end else if (ce) begin
			period_cnt_r <= base_tick ? 24'h000000 : period_cnt_r + 24'h000001;
		end
	end

	// per-port block counters, slow ports span ten base ticks
	// counters saturate; a zero threshold stops every enabled port
	genvar p;
	generate
		for (p = 0; p < `GCR_PORTS; p = p + 1) begin : g_storm
			reg  [10:0] blocks_r;
			reg  [3:0]  ticks_r;
			wire        period_end;
			wire        full;
			assign full       = (blocks_r >= storm_thr);
			assign period_end = base_tick & (~port_is_10m[p] | (ticks_r == TICKS_LAST));
			assign storm_limited[p] = storm_enable[p] & full;
			assign block_accept[p]  = block_request[p] & ~storm_limited[p];
			always @(posedge aclk) begin
				if (!aresetn) begin
					blocks_r <= 11'h000;
					ticks_r  <= 4'h0;
				end else if (ce) begin
					if (base_tick) begin
						ticks_r <= period_end ? 4'h0 : ticks_r + 4'h1;
					end
					if (period_end) begin
						blocks_r <= 11'h000;
					end else if (block_accept[p] && blocks_r != 11'h7FF) begin
						blocks_r <= blocks_r + 11'h001;
					end
				end
			end
		end
	endgenerate

	// led meaning select
	// led mode bit loads from its strap, then software owns it
	gcr_led_mux #(
		.N (`GCR_PORTS)
	) u_led (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.led_mode      (power_led_r[`GCR_LED_MODE_BIT]),
		.link_up       (link_up),
		.activity      (activity),
		.full_duplex   (full_duplex),
		.collision     (collision),
		.speed_100     (speed_100),
		.port_led_two  (port_led_two),
		.port_led_one  (port_led_one),
		.port_led_zero (port_led_zero)
	);

endmodule

// ===== gcr_regs_checker.sv
// assertion checker for the global control register bank
module gcr_regs_checker (
	input logic        aclk,              // core clock
	input logic        aresetn,           // sync reset
	input logic        ce,                // clock enable
	input logic        s_axi_bvalid,      // write answer
	input logic        s_axi_bready,      // write accept
	input logic        s_axi_rvalid,      // read answer
	input logic        s_axi_rready,      // read accept
	input logic        s_axi_arready,     // read address ready
	input logic [31:0] s_axi_rdata,       // read data
	input logic        sniff_src_match,   // source match
	input logic        sniff_dst_match,   // destination match
	input logic        sniff_mirror,      // mirror decision
	input logic        mii_back_pressure, // back pressure
	input logic        mii_half_duplex,   // half duplex
	input logic        mii_full_duplex,   // full duplex
	input logic        mii_flow_control,  // flow control
	input logic        vid_valid,         // vid strobe
	input logic [11:0] vid_in,            // vid in
	input logic        vid_out_valid,     // vid out strobe
	input logic [11:0] vid_out            // vid out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// mii setting outputs
	duplex_pair_a: assert property (mii_full_duplex != mii_half_duplex)
		else $error("duplex outputs not complementary");
	bp_gate_a: assert property (mii_back_pressure |-> mii_half_duplex)
		else $error("back pressure outside half duplex");
	flow_gate_a: assert property (mii_flow_control |-> mii_full_duplex)
		else $error("flow control outside full duplex");
	// mirroring and vid path
	sniff_both_a: assert property (sniff_src_match && sniff_dst_match |-> sniff_mirror)
		else $error("both ports matched but no mirror");
	vid_pass_a: assert property (ce && vid_valid && vid_in != 12'h000
		|=> vid_out_valid && vid_out == $past(vid_in)) else $error("non-null vid altered");
	// bus answers stand until taken
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped early");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed early");
	arready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	cover property (vid_out_valid);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (sniff_mirror && !sniff_dst_match);
endmodule

bind gcr_regs gcr_regs_checker i_gcr_regs_checker (.*);

// ===== gcr_regs_tb_top.sv
// self-checking bench for the global control register bank
module gcr_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic duplex_strap_pin, flow_control_strap_pin, speed_strap_pin, led_mode_strap_pin;
	logic sniff_src_match, sniff_dst_match, sniff_mirror, vid_valid, vid_out_valid;
	logic mii_back_pressure, mii_half_duplex, mii_full_duplex, mii_flow_control, mii_speed_10;
	logic [11:0] vid_in, port_vid, vid_out;
	logic [4:0] storm_enable, port_is_10m, block_request, block_accept, storm_limited;
	logic [4:0] link_up, activity, full_duplex, collision, speed_100;
	logic [4:0] port_led_two, port_led_one, port_led_zero;
	logic phy_power_save;
	int error_cnt, cmp_count, n, k, a0, a1, a2;
	gcr_regs #(.P_PERIOD_CYC(20)) i_gcr_regs (.*);
	// 20 MHz core clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// bounded wait ran out
	task tmo;
		if (n >= 200) begin
			error_cnt++;
			stop_test;
		end
	endtask
	task wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) break;
		end
		tmo;
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) break;
		end
		tmo;
		chk(s_axi_rdata, {24'h000000, e});
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// mii register value against bp, half, full, flow, 10M
	task mii(input logic [7:0] v, input logic [4:0] e);
		wr(6'h06, v, 2'h0);
		chk({mii_back_pressure, mii_half_duplex, mii_full_duplex, mii_flow_control,
			mii_speed_10}, e);
	endtask
	task vid(input logic [11:0] v, input logic [12:0] e);
		vid_in <= v;
		vid_valid <= 1'b1;
		@(posedge aclk);
		vid_valid <= 1'b0;
		@(posedge aclk);
		chk({vid_out_valid, vid_out}, e);
	endtask
	task led(input logic [7:0] m, input logic [14:0] e);
		wr(6'h0B, m, 2'h0);
		repeat (2) @(posedge aclk);
		chk({port_led_two, port_led_one, port_led_zero}, e);
	endtask
	// main sequence
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{duplex_strap_pin, flow_control_strap_pin, speed_strap_pin, led_mode_strap_pin} = 4'hB;
		{sniff_src_match, sniff_dst_match, vid_valid, vid_in, port_vid} = '0;
		{storm_enable, port_is_10m, block_request} = '0;
		{link_up, activity, full_duplex, collision, speed_100} = '0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// reset values, strap bits loaded
		rd(6'h05, 8'h00, 2'h0);
		rd(6'h06, 8'h50, 2'h0);
		rd(6'h07, 8'h4A, 2'h0);
		rd(6'h0B, 8'h02, 2'h0);
		chk({mii_half_duplex, mii_flow_control, mii_speed_10}, 3'b101);
		for (k = 8; k < 11; k++) begin
			rd(k[5:0], 8'h24, 2'h0);
			wr(k[5:0], 8'hA5, 2'h0);
			rd(k[5:0], 8'hA5, 2'h0);
		end
		// unmapped place and read-only upper bits
		wr(6'h04, 8'hFF, 2'h2);
		rd(6'h04, 8'h00, 2'h2);
		wr(6'h0B, 8'hFA, 2'h0);
		rd(6'h0B, 8'h0A, 2'h0);
		chk(phy_power_save, 1'b1);
		mii(8'hF0, 5'b11001);
		mii(8'hB0, 5'b00111);
		mii(8'h60, 5'b01000);
		mii(8'hA0, 5'b00110);
		// sniff mode against all match combinations
		for (k = 0; k < 8; k++) begin
			wr(6'h05, {7'h00, k[2]}, 2'h0);
			sniff_src_match <= k[1];
			sniff_dst_match <= k[0];
			repeat (2) @(posedge aclk);
			chk(sniff_mirror, k[2] ? (k[1] & k[0]) : (k[1] | k[0]));
		end
		// byte lane 0 off leaves the register alone
		s_axi_wstrb <= 4'hE;
		wr(6'h05, 8'h00, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(6'h05, 8'h01, 2'h0);
		port_vid <= 12'h123;
		wr(6'h06, 8'h08, 2'h0);
		vid(12'h000, 13'h1123);
		vid(12'h456, 13'h1456);
		wr(6'h06, 8'h00, 2'h0);
		vid(12'h000, 13'h1000);
		// storm threshold 3: port 0 fast, port 1 slow, port 2 unprotected
		wr(6'h07, 8'h03, 2'h0);
		storm_enable <= 5'h03;
		port_is_10m <= 5'h02;
		block_request <= 5'h07;
		{a0, a1, a2} = '0;
		repeat (200) begin
			@(posedge aclk);
			a0 += block_accept[0];
			a1 += block_accept[1];
			a2 += block_accept[2];
		end
		chk(a0 >= 30 && a0 <= 33, 1'b1);
		chk(a1 >= 3 && a1 <= 6, 1'b1);
		chk(a2, 200);
		// zero threshold stops enabled ports, a high threshold byte lifts the limit
		wr(6'h07, 8'h00, 2'h0);
		chk({storm_limited, block_accept}, {5'h03, 5'h04});
		wr(6'h06, 8'h01, 2'h0);
		chk({storm_limited, block_accept}, {5'h00, 5'h07});
		link_up <= 5'h1F;
		activity <= 5'h04;
		collision <= 5'h10;
		full_duplex <= 5'h03;
		speed_100 <= 5'h05;
		led(8'h00, {5'h1B, 5'h13, 5'h05});
		led(8'h02, {5'h01, 5'h1A, 5'h03});
		// clock enable low freezes the led registers
		ce <= 1'b0;
		link_up <= 5'h00;
		repeat (3) @(posedge aclk);
		chk({port_led_two, port_led_one, port_led_zero}, {5'h01, 5'h1A, 5'h03});
		ce <= 1'b1;
		repeat (2) @(posedge aclk);
		chk({port_led_two, port_led_one, port_led_zero}, {5'h00, 5'h00, 5'h03});
		// second reset with the straps at their pull-down levels
		{duplex_strap_pin, flow_control_strap_pin, speed_strap_pin, led_mode_strap_pin} <= 4'h0;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(6'h06, 8'h00, 2'h0);
		rd(6'h07, 8'h4A, 2'h0);
		rd(6'h0B, 8'h00, 2'h0);
		chk({mii_half_duplex, mii_full_duplex, mii_speed_10}, 3'b010);
		stop_test;
	end
endmodule
